// file: design/tcr_pkg.sv
package tcr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and register map
    localparam int unsigned TCR_DATA_W = 32;
    localparam int unsigned TCR_COUNT_W = 8;
    localparam logic [7:0] TCR_OFF_CONTROL = 8'h00;
    localparam logic [7:0] TCR_OFF_COUNTER = 8'h04;
    localparam logic [7:0] TCR_OFF_COMPARE = 8'h08;
    localparam logic [7:0] TCR_OFF_MASK = 8'h0C;
    localparam logic [7:0] TCR_OFF_FLAGS = 8'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] TCR_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TCR_COUNTER_RESET = 8'h00;
    localparam logic [7:0] TCR_COMPARE_RESET = 8'h00;
    localparam logic [1:0] TCR_MASK_RESET = 2'h0;
    localparam logic [1:0] TCR_FLAGS_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions of mask, flag and control registers
    localparam int unsigned TCR_OVF_BIT = 1;
    localparam int unsigned TCR_CMP_BIT = 0;
    localparam int unsigned TCR_FORCE_BIT = 7;
    localparam int unsigned TCR_COM_LSB = 4;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic force_compare_strobe;
        logic waveform_mode_lo;
        logic [1:0] compare_output_mode;
        logic waveform_mode_hi;
        logic [2:0] clock_source_select;
    } tcr_ctrl_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Waveform modes
    localparam logic [1:0] TCR_WGM_NORMAL = 2'h0;
    localparam logic [1:0] TCR_WGM_PHASE_PWM = 2'h1;
    localparam logic [1:0] TCR_WGM_CLEAR_ON_MATCH = 2'h2;
    localparam logic [1:0] TCR_WGM_FAST_PWM = 2'h3;
    localparam logic [7:0] TCR_MAX = 8'hFF;
    localparam logic [7:0] TCR_BOTTOM = 8'h00;

    // Compare output modes
    localparam logic [1:0] TCR_COM_OFF = 2'h0;
    localparam logic [1:0] TCR_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TCR_COM_CLEAR = 2'h2;
    localparam logic [1:0] TCR_COM_SET = 2'h3;

    // Clock sources and prescaler tap widths (log2 of divisor)
    localparam logic [2:0] TCR_CS_STOP = 3'h0;
    localparam logic [2:0] TCR_CS_EXT_RISE = 3'h7;
    localparam int unsigned TCR_TAP8_W = 3;
    localparam int unsigned TCR_TAP64_W = 6;
    localparam int unsigned TCR_TAP256_W = 8;
    localparam int unsigned TCR_TAP1024_W = 10;

    ////////////////////////////////////////////////////////////////////////////////
    // Count direction in phase correct mode
    typedef enum logic {TCR_DIR_UP, TCR_DIR_DOWN} tcr_dir_t;

    // Pin and interrupt carriers
    typedef struct packed {
        logic value;
        logic override;
    } tcr_pin_t;

    typedef struct packed {
        logic overflow_req;
        logic compare_req;
    } tcr_irq_t;

endpackage

// file: design/tcr_core.sv
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps

module tcr_core #(
    parameter int unsigned PRESCALE_W = 10,
    parameter int unsigned ADDR_W = 8
) (
    // Clock, reset and freeze
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [tcr_pkg::TCR_DATA_W-1:0] pwdata,
    output logic [tcr_pkg::TCR_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer pins
    input wire logic external_count_pin,
    output tcr_pkg::tcr_pin_t compare_output_pin,
    // Processor interrupt side
    input wire logic overflow_vector_ack,
    input wire logic compare_vector_ack,
    output tcr_pkg::tcr_irq_t irq
);
    import tcr_pkg::*;

    if (PRESCALE_W < TCR_TAP1024_W)
    begin : g_bad_prescale
        $error("PRESCALE_W must cover the divide-by-1024 tap");
    end
    if (ADDR_W < 8)
    begin : g_bad_addr
        $error("ADDR_W must reach every register offset");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State
    tcr_ctrl_t ctrl_reg;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [7:0] cmp_buf_reg;
    logic [7:0] cmp_active_reg;
    logic [7:0] cmp_active_next;
    logic [1:0] mask_reg;
    logic [1:0] flag_reg;
    tcr_dir_t dir_reg;
    tcr_dir_t dir_next;
    logic block_reg;
    logic oc_reg;
    logic oc_next;
    logic ovf_evt;
    logic [PRESCALE_W-1:0] pre_reg;
    logic ext_prev_reg;
    logic rd_loaded_reg;
    logic [TCR_DATA_W-1:0] prdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode; reads are sampled in the setup cycle so prdata comes from a flop
    wire logic sel_ctrl = paddr == ADDR_W'(TCR_OFF_CONTROL);
    wire logic sel_cnt = paddr == ADDR_W'(TCR_OFF_COUNTER);
    wire logic sel_cmp = paddr == ADDR_W'(TCR_OFF_COMPARE);
    wire logic sel_mask = paddr == ADDR_W'(TCR_OFF_MASK);
    wire logic sel_flag = paddr == ADDR_W'(TCR_OFF_FLAGS);
    wire logic mapped = sel_ctrl | sel_cnt | sel_cmp | sel_mask | sel_flag;
    wire logic rd_load = clk_en & psel & ~pwrite & ~rd_loaded_reg;
    wire logic wr_go = psel & penable & pwrite & clk_en;
    wire logic wr_ctrl = wr_go & sel_ctrl;
    wire logic wr_cnt = wr_go & sel_cnt;
    wire logic wr_cmp = wr_go & sel_cmp;
    wire logic wr_mask = wr_go & sel_mask;
    wire logic wr_flag = wr_go & sel_flag;
    wire tcr_ctrl_t wctrl = tcr_ctrl_t'(pwdata[7:0]);
    wire logic [7:0] rd_byte = sel_ctrl ? ctrl_reg :
                               sel_cnt ? cnt_reg :
                               sel_cmp ? cmp_buf_reg :
                               sel_mask ? {6'h00, mask_reg} :
                               sel_flag ? {6'h00, flag_reg} : 8'h00;

    assign pready = psel & penable & clk_en & (pwrite | rd_loaded_reg);
    assign pslverr = pready & ~mapped;
    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode
    wire logic [1:0] waveform_mode_bits = {ctrl_reg.waveform_mode_hi, ctrl_reg.waveform_mode_lo};
    wire logic [1:0] compare_output_mode = ctrl_reg.compare_output_mode;
    wire logic [2:0] clock_source_select = ctrl_reg.clock_source_select;
    wire logic mode_phase = waveform_mode_bits == TCR_WGM_PHASE_PWM;
    wire logic mode_fast = waveform_mode_bits == TCR_WGM_FAST_PWM;
    wire logic mode_pwm = mode_phase | mode_fast;
    wire logic wr_mode_pwm = wctrl.waveform_mode_lo;
    // TOP is the compare value only in clear-on-match mode
    wire logic [7:0] top_value = (waveform_mode_bits == TCR_WGM_CLEAR_ON_MATCH) ? cmp_active_reg : TCR_MAX;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock source; the pin is sampled whatever its direction, so software may drive it
    wire logic ext_rise = external_count_pin & ~ext_prev_reg;
    wire logic ext_fall = ~external_count_pin & ext_prev_reg;
    wire logic tap8 = &pre_reg[TCR_TAP8_W-1:0];
    wire logic tap64 = &pre_reg[TCR_TAP64_W-1:0];
    wire logic tap256 = &pre_reg[TCR_TAP256_W-1:0];
    wire logic tap1024 = &pre_reg[TCR_TAP1024_W-1:0];
    wire logic [7:0] tick_choice = {ext_rise, ext_fall, tap1024, tap256, tap64, tap8, 1'b1, 1'b0};
    wire logic tick = clk_en & tick_choice[clock_source_select];

    ////////////////////////////////////////////////////////////////////////////////
    // Compare events
    wire logic at_max = tick & (cnt_reg == TCR_MAX);
    wire logic match_evt = tick & (cnt_reg == cmp_active_reg) & ~block_reg;
    wire logic force_evt = wr_ctrl & wctrl.force_compare_strobe & ~wr_mode_pwm;
    wire logic pwm_special = compare_output_mode[1] & (cmp_active_reg == TCR_MAX);
    wire logic pwm_top_act = mode_pwm & compare_output_mode[1] & at_max & (mode_fast | pwm_special);
    // A forced match acts with the output mode being written, never the old one
    wire logic [1:0] act_com = force_evt ? wctrl.compare_output_mode : compare_output_mode;

    ////////////////////////////////////////////////////////////////////////////////
    // Counter sequence
    always_comb
    begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        ovf_evt = 1'b0;
        if (tick)
        begin
            case (waveform_mode_bits)
                TCR_WGM_PHASE_PWM:
                begin
                    case (dir_reg)
                        TCR_DIR_UP:
                        begin
                            if (cnt_reg == TCR_MAX)
                            begin
                                cnt_next = cnt_reg - 8'h01;
                                dir_next = TCR_DIR_DOWN;
                            end
                            else
                            begin
                                cnt_next = cnt_reg + 8'h01;
                            end
                        end
                        TCR_DIR_DOWN:
                        begin
                            if (cnt_reg == TCR_BOTTOM)
                            begin
                                cnt_next = cnt_reg + 8'h01;
                                dir_next = TCR_DIR_UP;
                                ovf_evt = 1'b1;
                            end
                            else
                            begin
                                cnt_next = cnt_reg - 8'h01;
                            end
                        end
                        default: dir_next = TCR_DIR_UP;
                    endcase
                end
                default:
                begin
                    // Forced matches never reach here, so they cannot clear the counter
                    cnt_next = (cnt_reg == top_value) ? TCR_BOTTOM : cnt_reg + 8'h01;
                    ovf_evt = cnt_reg == TCR_MAX;
                end
            endcase
        end
        if (wr_cnt)
        begin
            cnt_next = pwdata[7:0];
        end
    end

    // Compare buffer: immediate outside PWM, otherwise transferred at TOP
    always_comb
    begin
        cmp_active_next = cmp_active_reg;
        if (!mode_pwm)
        begin
            cmp_active_next = wr_cmp ? pwdata[7:0] : cmp_buf_reg;
        end
        else if (at_max)
        begin
            cmp_active_next = cmp_buf_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Waveform output
    always_comb
    begin
        oc_next = oc_reg;
        if (!mode_pwm || force_evt)
        begin
            if (match_evt || force_evt)
            begin
                case (act_com)
                    TCR_COM_TOGGLE: oc_next = ~oc_reg;
                    TCR_COM_CLEAR: oc_next = 1'b0;
                    TCR_COM_SET: oc_next = 1'b1;
                    default: oc_next = oc_reg;
                endcase
            end
        end
        else if (compare_output_mode[1])
        begin
            if (pwm_top_act)
            begin
                oc_next = ~compare_output_mode[0];
            end
            else if (match_evt && !pwm_special)
            begin
                // Up-count and fast matches take mode bit 0, down-count matches its inverse
                oc_next = (mode_fast || dir_reg == TCR_DIR_UP) ? compare_output_mode[0] :
                          ~compare_output_mode[0];
            end
        end
    end

    // Pin value stays latched when disconnected so reconnecting shows no glitch
    assign compare_output_pin.value = oc_reg;
    assign compare_output_pin.override = compare_output_mode != TCR_COM_OFF;

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= tcr_ctrl_t'(TCR_CONTROL_RESET);
            mask_reg <= TCR_MASK_RESET;
            cnt_reg <= TCR_COUNTER_RESET;
            cmp_buf_reg <= TCR_COMPARE_RESET;
            cmp_active_reg <= TCR_COMPARE_RESET;
            dir_reg <= TCR_DIR_UP;
            block_reg <= 1'b0;
            oc_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_ctrl)
            begin
                ctrl_reg <= {1'b0, wctrl[TCR_FORCE_BIT-1:0]};
            end
            if (wr_mask)
            begin
                mask_reg <= pwdata[1:0];
            end
            if (wr_cmp)
            begin
                cmp_buf_reg <= pwdata[7:0];
            end
            cnt_reg <= cnt_next;
            cmp_active_reg <= cmp_active_next;
            dir_reg <= dir_next;
            block_reg <= wr_cnt | (block_reg & ~tick);
            oc_reg <= oc_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_reg <= '0;
            ext_prev_reg <= 1'b0;
            rd_loaded_reg <= 1'b0;
            prdata_reg <= '0;
        end
        else if (clk_en)
        begin
            pre_reg <= pre_reg + PRESCALE_W'(1);
            ext_prev_reg <= external_count_pin;
            rd_loaded_reg <= pready ? 1'b0 : (rd_loaded_reg | rd_load);
            if (rd_load)
            begin
                prdata_reg <= TCR_DATA_W'(rd_byte);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags: hardware set wins over vector or write-one clear
    wire logic [1:0] flag_set = {ovf_evt, match_evt};
    wire logic [1:0] flag_ack = {overflow_vector_ack, compare_vector_ack};
    wire logic [1:0] flag_w1c = wr_flag ? pwdata[1:0] : 2'h0;

    for (genvar gi = 0; gi < 2; gi++)
    begin : g_flag
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                flag_reg[gi] <= TCR_FLAGS_RESET[gi];
            end
            else if (clk_en)
            begin
                flag_reg[gi] <= flag_set[gi] | (flag_reg[gi] & ~flag_w1c[gi] & ~flag_ack[gi]);
            end
        end
    end

    // Global enable and vectoring stay with the processor
    assign irq.overflow_req = flag_reg[TCR_OVF_BIT] & mask_reg[TCR_OVF_BIT];
    assign irq.compare_req = flag_reg[TCR_CMP_BIT] & mask_reg[TCR_CMP_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking tcr_cb @(posedge pclk iff clk_en);
    endclocking
    default disable iff (!presetn);

    a_force_no_flag: assert property (
        force_evt && !match_evt && !compare_vector_ack && !tick |=> flag_reg[0] == $past(flag_reg[0])
            && cnt_reg == $past(cnt_reg))
        else $error("forced match changed flag or counter");
    a_force_sets_pin: assert property (
        force_evt && wctrl.compare_output_mode == TCR_COM_SET |=> compare_output_pin.value)
        else $error("forced set did not drive the output high");
    a_force_pwm_idle: assert property (
        wr_ctrl && wctrl.force_compare_strobe && wr_mode_pwm && !tick |=> oc_reg == $past(oc_reg))
        else $error("force strobe acted in a PWM mode");
    a_ctrl_reads_zero: assert property (
        pready && !pwrite && sel_ctrl |-> !prdata[TCR_FORCE_BIT])
        else $error("force strobe read back as one");
    a_overflow_at_max: assert property (
        at_max && !mode_phase |=> flag_reg[TCR_OVF_BIT])
        else $error("overflow flag missed at MAX");
    a_phase_bottom_turn: assert property (
        tick && mode_phase && dir_reg == TCR_DIR_DOWN && cnt_reg == TCR_BOTTOM && !wr_cnt
            |=> flag_reg[TCR_OVF_BIT] && dir_reg == TCR_DIR_UP && cnt_reg == 8'h01)
        else $error("phase mode bottom turnaround wrong");
    a_phase_max_hold: assert property (
        tick && mode_phase && dir_reg == TCR_DIR_UP && cnt_reg == TCR_MAX && !wr_cnt
            |=> cnt_reg == 8'hFE && dir_reg == TCR_DIR_DOWN)
        else $error("phase mode did not turn after one tick at MAX");
    a_match_restart: assert property (
        tick && waveform_mode_bits == TCR_WGM_CLEAR_ON_MATCH && cnt_reg == cmp_active_reg && !wr_cnt
            |=> cnt_reg == TCR_BOTTOM)
        else $error("clear-on-match mode did not restart");
    a_write_blocks_match: assert property (
        wr_cnt ##1 tick |-> !match_evt)
        else $error("match not blocked after counter write");
    a_pwm_cmp_buffered: assert property (
        mode_pwm && wr_cmp && !at_max |=> cmp_active_reg == $past(cmp_active_reg))
        else $error("compare value bypassed buffer in PWM");
    a_override_follows: assert property (
        wr_ctrl |=> compare_output_pin.override == ($past(pwdata[TCR_COM_LSB+1:TCR_COM_LSB]) != 2'h0))
        else $error("pin override does not follow output mode");
    a_flag_set_wins: assert property (
        match_evt && wr_flag && pwdata[TCR_CMP_BIT] |=> flag_reg[TCR_CMP_BIT])
        else $error("compare event lost to clear");

    c_phase_match: cover property (match_evt && mode_phase && dir_reg == TCR_DIR_DOWN);
    c_forced: cover property (force_evt && wctrl.compare_output_mode == TCR_COM_TOGGLE);
    c_ext_tick: cover property (tick && clock_source_select == TCR_CS_EXT_RISE);
    c_fast_overflow: cover property (at_max && mode_fast && irq.overflow_req == 1'b0 ##1 irq.overflow_req);

endmodule

// file: bench/tcr_cpu_model.sv
`timescale 1ns/1ps

module tcr_cpu_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Processor interrupt side
    input wire logic global_irq_enable,
    input wire tcr_pkg::tcr_irq_t irq,
    output logic overflow_vector_ack,
    output logic compare_vector_ack
);
    import tcr_pkg::*;

    logic ovf_ack_reg;
    logic cmp_ack_reg;
    // One vector per request; the pause after a pulse lets the flag drop first
    wire logic ovf_ack_next = global_irq_enable & irq.overflow_req & ~ovf_ack_reg;
    wire logic cmp_ack_next = global_irq_enable & irq.compare_req & ~cmp_ack_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ovf_ack_reg <= 1'b0;
            cmp_ack_reg <= 1'b0;
        end
        else
        begin
            ovf_ack_reg <= ovf_ack_next;
            cmp_ack_reg <= cmp_ack_next;
        end
    end

    assign overflow_vector_ack = ovf_ack_reg;
    assign compare_vector_ack = cmp_ack_reg;
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import tcr_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic external_count_pin = 1'b0;
    logic gie = 1'b0;
    logic ovf_ack;
    logic cmp_ack;
    tcr_pin_t pin;
    tcr_irq_t irq;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] offs [5] = '{TCR_OFF_CONTROL, TCR_OFF_COUNTER, TCR_OFF_COMPARE, TCR_OFF_MASK, TCR_OFF_FLAGS};
    // Force table: last two are PWM modes, where the strobe must leave the pin alone
    logic [7:0] fctl [5] = '{8'hB8, 8'hA8, 8'h98, 8'hE8, 8'hE0};
    logic fpin [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    int taps [4] = '{TCR_TAP8_W, TCR_TAP64_W, TCR_TAP256_W, TCR_TAP1024_W};

    always #2.5 pclk = ~pclk;

    tcr_core #(.PRESCALE_W(10), .ADDR_W(8)) i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_count_pin(external_count_pin),
        .compare_output_pin(pin), .overflow_vector_ack(ovf_ack), .compare_vector_ack(cmp_ack), .irq(irq));

    tcr_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .global_irq_enable(gie), .irq(irq),
        .overflow_vector_ack(ovf_ack), .compare_vector_ack(cmp_ack));

    task automatic report_and_stop;
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Leading idle edge keeps a release and the next request out of one time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Return mid-cycle so callers look at settled outputs
        @(negedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check(rd, {24'h00_0000, e});
    endtask

    // Timer runs for exactly k+3 clock edges between the two control writes
    task automatic run(input logic [7:0] ctl, input int k);
        wr(TCR_OFF_CONTROL, ctl);
        repeat (k) @(posedge pclk);
        wr(TCR_OFF_CONTROL, ctl & 8'h78);
    endtask

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (offs[i]) rchk(offs[i], 8'h00);
        check(32'(pin.override), 32'h0000_0000);
        apb(1'b0, 8'h14, 8'h00);
        check(32'(err), 32'h0000_0001);
        check(rd, 32'h0000_0000);
        wr(TCR_OFF_COUNTER, 8'h05);
        foreach (fctl[i])
        begin
            wr(TCR_OFF_CONTROL, fctl[i]);
            rchk(TCR_OFF_CONTROL, fctl[i] & 8'h7F);
            check(32'(pin.value), 32'(fpin[i]));
            check(32'(pin.override), 32'h0000_0001);
        end
        wr(TCR_OFF_CONTROL, 8'h08);
        rchk(TCR_OFF_COUNTER, 8'h05);
        rchk(TCR_OFF_FLAGS, 8'h00);
        check(32'(pin.override), 32'h0000_0000);
        wr(TCR_OFF_COMPARE, 8'h03);
        wr(TCR_OFF_COUNTER, 8'h00);
        wr(TCR_OFF_MASK, 8'h03);
        rchk(TCR_OFF_MASK, 8'h03);
        run(8'h11, 1);
        rchk(TCR_OFF_COUNTER, 8'h04);
        rchk(TCR_OFF_FLAGS, 8'h01);
        check(32'(pin.value), 32'h0000_0000);
        check(32'(irq.compare_req), 32'h0000_0001);
        wr(TCR_OFF_MASK, 8'h00);
        check(32'(irq.compare_req), 32'h0000_0000);
        wr(TCR_OFF_FLAGS, 8'h01);
        rchk(TCR_OFF_FLAGS, 8'h00);
        wr(TCR_OFF_COUNTER, 8'h03);
        run(8'h11, 0);
        rchk(TCR_OFF_FLAGS, 8'h00);
        rchk(TCR_OFF_COUNTER, 8'h06);
        wr(TCR_OFF_MASK, 8'h03);
        wr(TCR_OFF_COUNTER, 8'hFE);
        run(8'h11, 0);
        rchk(TCR_OFF_COUNTER, 8'h01);
        rchk(TCR_OFF_FLAGS, 8'h02);
        check(32'(irq.overflow_req), 32'h0000_0001);
        @(posedge pclk);
        gie <= 1'b1;
        while (irq.overflow_req === 1'b1) @(posedge pclk);
        gie <= 1'b0;
        rchk(TCR_OFF_FLAGS, 8'h00);
        wr(TCR_OFF_COUNTER, 8'hF0);
        run(8'h41, 37);
        rchk(TCR_OFF_COUNTER, 8'hE6);
        rchk(TCR_OFF_FLAGS, 8'h00);
        // Still counting down from the run above, so this crosses the bottom turnaround
        wr(TCR_OFF_COUNTER, 8'h02);
        run(8'h41, 1);
        rchk(TCR_OFF_COUNTER, 8'h02);
        rchk(TCR_OFF_FLAGS, 8'h02);
        wr(TCR_OFF_FLAGS, 8'h02);
        wr(TCR_OFF_CONTROL, 8'hB0);
        wr(TCR_OFF_CONTROL, 8'h68);
        wr(TCR_OFF_COMPARE, 8'h10);
        wr(TCR_OFF_COUNTER, 8'h00);
        run(8'h69, 1);
        rchk(TCR_OFF_FLAGS, 8'h01);
        check(32'(pin.value), 32'h0000_0000);
        rchk(TCR_OFF_COMPARE, 8'h10);
        wr(TCR_OFF_FLAGS, 8'h01);
        wr(TCR_OFF_COMPARE, 8'h03);
        wr(TCR_OFF_COUNTER, 8'h00);
        run(8'h09, 2);
        rchk(TCR_OFF_COUNTER, 8'h01);
        rchk(TCR_OFF_FLAGS, 8'h01);
        foreach (taps[i])
        begin
            wr(TCR_OFF_COUNTER, 8'h00);
            run(8'(i + 2), (2 << taps[i]) - 3);
            rchk(TCR_OFF_COUNTER, 8'h02);
        end
        // Ten frozen edges must not count
        wr(TCR_OFF_COUNTER, 8'h00);
        wr(TCR_OFF_CONTROL, 8'h01);
        @(posedge pclk);
        clk_en <= 1'b0;
        repeat (10) @(posedge pclk);
        clk_en <= 1'b1;
        wr(TCR_OFF_CONTROL, 8'h00);
        rchk(TCR_OFF_COUNTER, 8'h04);
        for (int cs = 6; cs < 8; cs++)
        begin
            wr(TCR_OFF_COUNTER, 8'h00);
            wr(TCR_OFF_CONTROL, 8'(cs));
            repeat (3)
            begin
                repeat (2) @(posedge pclk);
                external_count_pin <= 1'b1;
                repeat (2) @(posedge pclk);
                external_count_pin <= 1'b0;
            end
            wr(TCR_OFF_CONTROL, 8'h00);
            rchk(TCR_OFF_COUNTER, 8'h03);
        end
        report_and_stop();
    end
endmodule
